// File: rtl/fws_pkg.sv
// Constants, register map and state type for the flash write-status host.
// Assumes a 10 MHz APB clock and an asynchronous parallel flash on the pins.
package fws_pkg;

  // Clock rate and flash timing, in ns (least times, rounded up)
  localparam int unsigned CLK_MHZ    = 10;
  localparam int unsigned T_ACC_NS   = 120;  // Output strobe to valid data
  localparam int unsigned T_WP_NS    = 50;   // Write strobe low width
  localparam int unsigned T_RECOV_NS = 30;   // Strobe high between cycles
  localparam int unsigned SYNC_CYC   = 2;    // Extra wait for the data synchroniser
  localparam logic [2:0]  RD_CYC     = 3'((T_ACC_NS * CLK_MHZ + 999) / 1000 + SYNC_CYC);
  localparam logic [2:0]  WP_CYC     = 3'((T_WP_NS * CLK_MHZ + 999) / 1000);
  localparam logic [2:0]  GAP_CYC    = 3'((T_RECOV_NS * CLK_MHZ + 999) / 1000);

  // Widths
  localparam int unsigned AW = 18;  // Flash word address
  localparam int unsigned DW = 16;  // Flash data bus

  // Register byte offsets
  localparam logic [11:0] OFF_CTRL   = 12'h000;
  localparam logic [11:0] OFF_ADDR   = 12'h004;
  localparam logic [11:0] OFF_WDATA  = 12'h008;
  localparam logic [11:0] OFF_STATUS = 12'h00c;
  localparam logic [11:0] OFF_RDATA  = 12'h010;

  // Control fields
  localparam int unsigned CTRL_START = 0;
  localparam int unsigned CTRL_OP_LO = 1;

  // Operations
  localparam logic [1:0] OP_WRITE = 2'h0;  // One bus write cycle
  localparam logic [1:0] OP_READ  = 2'h1;  // One bus read cycle
  localparam logic [1:0] OP_POLLD = 2'h2;  // Polling-bit wait
  localparam logic [1:0] OP_POLLT = 2'h3;  // Activity-toggle wait

  // Status bit positions
  localparam int unsigned ST_BUSY    = 0;
  localparam int unsigned ST_DONE    = 1;
  localparam int unsigned ST_FAIL    = 2;
  localparam int unsigned ST_RDY_PIN = 3;
  localparam int unsigned ST_SECT    = 4;
  localparam int unsigned ST_TMO     = 5;
  localparam int unsigned ST_ETMR    = 6;

  // Data-bus status bit positions
  localparam int unsigned POLL_BIT = 7;
  localparam int unsigned ACT_BIT  = 6;
  localparam int unsigned TMO_BIT  = 5;
  localparam int unsigned ETMR_BIT = 3;
  localparam int unsigned SECT_BIT = 2;

  // Reset values
  localparam logic [AW-1:0] ADDR_RST = 18'h00000;
  localparam logic [DW-1:0] DATA_RST = 16'h0000;

  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SETUP,
    ST_PULSE,
    ST_GAP,
    ST_EVAL
  } fws_state_e;

endpackage : fws_pkg

// File: rtl/fws_host.sv
// Host controller that drives an asynchronous flash and tracks write status.
// Assumes software on APB starts each bus cycle or status wait, and that the
// flash data and ready/busy pins sit outside the pclk domain.
`timescale 1ns/1ns
module fws_host
  import fws_pkg::*;
(
  // Clock and reset
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  // APB slave
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [11:0]            paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  // Flash control pins
  output logic                        flash_ce_n,
  output logic                        flash_oe_n,
  output logic                        flash_we_n,
  output logic      [fws_pkg::AW-1:0] flash_addr,
  // Flash data bus, split into three signals
  input  wire logic [fws_pkg::DW-1:0] flash_dq_in,
  output logic      [fws_pkg::DW-1:0] flash_dq_out,
  output logic                        flash_dq_oe,
  // Open-drain ready/busy line, observed only
  input  wire logic                   ready_busy_out_n
);
  import fws_pkg::*;

  // Register map decode, shared by read and write paths
  function automatic logic mapped(input logic [11:0] a);
    mapped = (a == OFF_CTRL) || (a == OFF_ADDR) || (a == OFF_WDATA) ||
             (a == OFF_STATUS) || (a == OFF_RDATA);
  endfunction : mapped

  fws_state_e      state_q;      // Sequencer state
  logic [2:0]      cnt_q;        // Pulse and gap counter
  logic [1:0]      op_q;         // Operation in progress
  logic            is_rd_q;      // Current cycle is a read
  logic [AW-1:0]   addr_q;       // Software address register
  logic [DW-1:0]   wdata_q;      // Write data or expected value
  logic [DW-1:0]   rdata_q;      // Last captured read data
  logic [DW-1:0]   prev_q;       // Previous read, for toggle compare
  logic            have_prev_q;  // Prev holds a real sample
  logic            recheck_q;    // Timeout flag seen once
  logic            final_q;      // Next read is the clean data read
  logic            done_q;       // Sticky completion
  logic            fail_q;       // Sticky failure
  logic            sect_q;       // Sector bit seen toggling
  logic [DW-1:0]   dq_s1_q;      // Data synchroniser stages
  logic [DW-1:0]   dq_s2_q;
  logic [DW-1:0]   dq_s3_q;
  logic [2:0]      rb_sync_q;    // Ready/busy synchroniser stages
  logic            rb_lvl_q;     // Filtered ready/busy level
  logic [31:0]     prdata_q;     // Read data latched at setup
  logic            wr_en;        // APB write access phase
  logic            start;        // Software start request
  logic            eval_read;    // Read result being judged
  logic            done_set;
  logic            fail_set;
  logic            next_read;    // Eval asks for another read
  logic [DW-1:0]   dq_now;       // Stable sample at end of strobe

  // Zero-wait slave; errors only for unmapped addresses
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped(paddr);
  assign prdata  = prdata_q;
  assign wr_en   = psel && penable && pwrite && mapped(paddr);
  assign start   = wr_en && (paddr == OFF_CTRL) && pwdata[CTRL_START] &&
                   (state_q == ST_IDLE);
  assign dq_now  = dq_s3_q;
  assign eval_read = (state_q == ST_EVAL) && is_rd_q;

  // Decide the outcome of one read during a status wait
  always_comb begin
    done_set  = 1'b0;
    fail_set  = 1'b0;
    next_read = 1'b0;
    if (state_q == ST_EVAL) begin
      if (!is_rd_q || op_q == OP_READ || final_q) begin
        done_set = 1'b1;
      end else if (op_q == OP_POLLD) begin
        if (rdata_q[POLL_BIT] == wdata_q[POLL_BIT]) begin
          next_read = 1'b1;
        end else if (recheck_q) begin
          fail_set = 1'b1;
        end else begin
          next_read = 1'b1;
        end
      end else begin
        if (have_prev_q && rdata_q[ACT_BIT] == prev_q[ACT_BIT]) begin
          next_read = 1'b1;
        end else if (have_prev_q && recheck_q) begin
          fail_set = 1'b1;
        end else begin
          next_read = 1'b1;
        end
      end
    end
  end

  // Sequencer: setup, strobe, recovery gap, evaluation
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_IDLE;
      cnt_q   <= 3'h0;
      op_q    <= OP_WRITE;
      is_rd_q <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (start) begin
            op_q    <= pwdata[CTRL_OP_LO +: 2];
            is_rd_q <= (pwdata[CTRL_OP_LO +: 2] != OP_WRITE);
            state_q <= ST_SETUP;
          end
        end
        ST_SETUP: begin                           // Address settles first
          cnt_q   <= is_rd_q ? RD_CYC : WP_CYC;
          state_q <= ST_PULSE;
        end
        ST_PULSE: begin
          if (cnt_q <= 3'h1) begin
            cnt_q   <= GAP_CYC;
            state_q <= ST_GAP;
          end else begin
            cnt_q <= cnt_q - 3'h1;
          end
        end
        ST_GAP: begin                             // Separates read cycles
          if (cnt_q <= 3'h1) begin
            state_q <= ST_EVAL;
          end else begin
            cnt_q <= cnt_q - 3'h1;
          end
        end
        ST_EVAL: begin
          state_q <= next_read ? ST_SETUP : ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Pin drive; address held for the whole wait
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flash_ce_n   <= 1'b1;
      flash_oe_n   <= 1'b1;
      flash_we_n   <= 1'b1;
      flash_dq_oe  <= 1'b0;
      flash_addr   <= ADDR_RST;
      flash_dq_out <= DATA_RST;
    end else begin
      flash_addr   <= addr_q;
      flash_dq_out <= wdata_q;
      // Chip select stays low across a wait; reads paced by output strobe
      flash_ce_n  <= (state_q == ST_IDLE && !start) ||
                     (state_q == ST_EVAL && !next_read);
      flash_oe_n  <= !(is_rd_q && state_q == ST_SETUP) &&
                     !(is_rd_q && state_q == ST_PULSE && cnt_q > 3'h1);
      flash_we_n  <= !(!is_rd_q && state_q == ST_SETUP) &&
                     !(!is_rd_q && state_q == ST_PULSE && cnt_q > 3'h1);
      // Drive data only around a write so the bus never fights the flash
      flash_dq_oe <= !is_rd_q && (state_q == ST_SETUP || state_q == ST_PULSE);
    end
  end

  // Data and ready/busy synchronisers, three stages each
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dq_s1_q   <= DATA_RST;
      dq_s2_q   <= DATA_RST;
      dq_s3_q   <= DATA_RST;
      rb_sync_q <= 3'h7;
      rb_lvl_q  <= 1'b1;
    end else begin
      dq_s1_q   <= flash_dq_in;
      dq_s2_q   <= dq_s1_q;
      dq_s3_q   <= dq_s2_q;
      rb_sync_q <= {rb_sync_q[1:0], ready_busy_out_n};
      if (rb_sync_q[1] == rb_sync_q[2]) begin
        rb_lvl_q <= rb_sync_q[2];
      end
    end
  end

  // Capture read data at the last strobe cycle; keep toggle history
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q     <= DATA_RST;
      prev_q      <= DATA_RST;
      have_prev_q <= 1'b0;
      recheck_q   <= 1'b0;
      final_q     <= 1'b0;
      sect_q      <= 1'b0;
    end else if (start) begin
      have_prev_q <= 1'b0;
      recheck_q   <= 1'b0;
      final_q     <= 1'b0;
      sect_q      <= 1'b0;
    end else begin
      if (state_q == ST_PULSE && cnt_q <= 3'h1 && is_rd_q) begin
        rdata_q <= dq_now;
      end
      if (eval_read && !final_q) begin
        prev_q      <= rdata_q;
        have_prev_q <= 1'b1;
        if (have_prev_q && rdata_q[SECT_BIT] != prev_q[SECT_BIT]) begin
          sect_q <= 1'b1;
        end
        if (rdata_q[TMO_BIT]) begin
          recheck_q <= 1'b1;
        end
        if (next_read && (op_q == OP_POLLD ?
            rdata_q[POLL_BIT] == wdata_q[POLL_BIT] :
            have_prev_q && rdata_q[ACT_BIT] == prev_q[ACT_BIT])) begin
          final_q <= 1'b1;
        end
      end
    end
  end

  // Software registers; address and data locked while busy
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_q  <= ADDR_RST;
      wdata_q <= DATA_RST;
    end else if (wr_en && state_q == ST_IDLE) begin
      if (paddr == OFF_ADDR) begin
        addr_q <= pwdata[AW-1:0];
      end
      if (paddr == OFF_WDATA) begin
        wdata_q <= pwdata[DW-1:0];
      end
    end
  end

  // Sticky outcome; a start clears, but a same-cycle set would win
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_q <= 1'b0;
      fail_q <= 1'b0;
    end else begin
      done_q <= done_set || (done_q && !start);
      fail_q <= fail_set || (fail_q && !start);
    end
  end

  // Read data latched in the setup phase, valid in the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h00000000;
    end else if (psel && !penable) begin
      case (paddr)
        OFF_CTRL:   prdata_q <= {29'h0, op_q, 1'b0};
        OFF_ADDR:   prdata_q <= {14'h0, addr_q};
        OFF_WDATA:  prdata_q <= {16'h0, wdata_q};
        OFF_STATUS: prdata_q <= {25'h0, rdata_q[ETMR_BIT], rdata_q[TMO_BIT],
                                 sect_q, rb_lvl_q, fail_q, done_q, state_q != ST_IDLE};
        OFF_RDATA:  prdata_q <= {16'h0, rdata_q};
        default:    prdata_q <= 32'h00000000;
      endcase
    end
  end

endmodule : fws_host

// File: verif/fws_host_monitor.sv
// Pin and APB assertions for the flash write-status host.
// Assumes one pclk domain with presetn as its reset.
`timescale 1ns/1ns
module fws_host_monitor
  import fws_pkg::*;
(
  // Clock, reset and APB
  input wire logic                   pclk,
  input wire logic                   presetn,
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic [11:0]            paddr,
  input wire logic                   pready,
  input wire logic                   pslverr,
  // Flash pins
  input wire logic                   flash_ce_n,
  input wire logic                   flash_oe_n,
  input wire logic                   flash_we_n,
  input wire logic [fws_pkg::AW-1:0] flash_addr,
  input wire logic                   flash_dq_oe
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Read strobe of four cycles, then released
  sequence s_read_pulse;
    !flash_oe_n [*4] ##1 flash_oe_n;
  endsequence
  // Write strobe of one cycle: low after setup, released as the pulse count ends
  sequence s_write_pulse;
    !flash_we_n [*1] ##1 flash_we_n;
  endsequence
  property p_oe_width; $fell(flash_oe_n) |-> s_read_pulse; endproperty
  property p_we_width; $fell(flash_we_n) |-> s_write_pulse; endproperty
  property p_oe_gap; $rose(flash_oe_n) |=> flash_oe_n; endproperty
  property p_addr_hold; !flash_ce_n && $past(!flash_ce_n) |-> $stable(flash_addr); endproperty
  property p_no_fight; !flash_oe_n |-> !flash_dq_oe && flash_we_n; endproperty
  property p_we_drive; !flash_we_n |-> !flash_ce_n && flash_dq_oe; endproperty
  property p_ce_idle; flash_ce_n |-> flash_oe_n && flash_we_n && !flash_dq_oe; endproperty
  property p_ready; psel && penable |-> pready; endproperty
  property p_slverr; psel && penable && paddr[1:0] == 2'b00 |-> pslverr == (paddr > OFF_RDATA);
  endproperty
  a_oe_width: assert property (p_oe_width) else $error("read strobe width wrong");
  a_we_width: assert property (p_we_width) else $error("write strobe width wrong");
  a_oe_gap: assert property (p_oe_gap) else $error("reads not separated");
  a_addr_hold: assert property (p_addr_hold) else $error("address moved in wait");
  a_no_fight: assert property (p_no_fight) else $error("bus driven during read");
  a_we_drive: assert property (p_we_drive) else $error("write without data drive");
  a_ce_idle: assert property (p_ce_idle) else $error("strobe while deselected");
  a_ready: assert property (p_ready) else $error("access not answered");
  a_slverr: assert property (p_slverr) else $error("slave error wrong");
endmodule : fws_host_monitor
bind fws_host fws_host_monitor i_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
  .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n),
  .flash_addr(flash_addr), .flash_dq_oe(flash_dq_oe));

// File: verif/fws_flash_model.sv
// Behavioural flash: write status on reads of the busy bank.
// Assumes the bench pulls the open-drain ready/busy line up.
`timescale 1ns/1ns
module fws_flash_model
  import fws_pkg::*;
(
  // Host pins
  input  wire logic                   ce_n,
  input  wire logic                   oe_n,
  input  wire logic                   we_n,
  input  wire logic [fws_pkg::AW-1:0] addr,
  input  wire logic [fws_pkg::DW-1:0] din,
  output logic      [fws_pkg::DW-1:0] dout,
  output logic                        rb_low,
  // Scenario controls
  input  wire logic                   erase,
  input  wire logic                   stuck,
  input  wire logic                   susp,
  input  wire logic [3:0]             nbusy
);
  logic [DW-1:0] mem_q = '0;   // Programmed word
  logic [DW-1:0] last_q = '0;  // Last driven value
  logic [DW-1:0] stat, val;
  logic [AW-1:0] pa_q = '0;    // Command address
  logic [3:0]    left_q = '0;  // Busy reads left
  logic          busy_q = 1'b0;
  logic          tog_q = 1'b0;
  logic          stog_q = 1'b0;
  logic          hit;
  logic          we_d = 1'b1;  // Strobe levels seen last, for edge finding
  logic          oe_d = 1'b1;
  assign hit = busy_q && (addr[17:16] == pa_q[17:16]);
  // Status word of the busy bank
  always_comb begin
    stat = mem_q;
    stat[7] = erase ? susp : ~mem_q[7];
    stat[6] = tog_q;
    stat[5] = stuck;
    stat[3] = erase;
    stat[2] = erase ? stog_q : mem_q[2];
    val = hit ? stat : ((addr == pa_q) ? mem_q : addr[15:0]);
  end
  // Released bus shows the inverse so a stale value never passes
  assign dout = (!ce_n && !oe_n) ? val : ~last_q;
  assign rb_low = busy_q && !(erase && susp);
  // Command at the end of the write strobe, toggles at the end of each busy-bank read;
  // one process so the busy count and busy flag have a single driver
  always @(we_n or oe_n) begin
    if (we_n === 1'b1 && we_d === 1'b0 && ce_n === 1'b0) begin
      mem_q <= din;
      pa_q <= addr;
      left_q <= nbusy;
      busy_q <= (nbusy != 4'h0);  // Zero reads means reset
    end
    if (oe_n === 1'b1 && oe_d === 1'b0 && ce_n === 1'b0) begin
      last_q <= val;
      if (hit) begin
        tog_q <= (erase && susp) ? tog_q : ~tog_q;
        stog_q <= erase ? ~stog_q : stog_q;
        left_q <= left_q - 4'h1;
        if (left_q == 4'h1 && !stuck && !susp) busy_q <= 1'b0;
      end
    end
    we_d <= we_n;
    oe_d <= oe_n;
  end
endmodule : fws_flash_model

// File: verif/fws_host_tb.sv
// Self-checking bench for the flash write-status host.
// Assumes the flash model on the pins and a pull-up on ready/busy.
`timescale 1ns/1ns
module fws_host_tb;
  import fws_pkg::*;
  logic          pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic          ce_n, oe_n, we_n, dq_oe, rb_low, rb_n, erase, stuck, susp;
  logic [11:0]   paddr;
  logic [31:0]   pwdata, prdata, rd, seed, st;
  logic [AW-1:0] fa;
  logic [DW-1:0] fo, fi, d;
  logic [3:0]    nbusy;
  int            miscompares, n_tests;
  assign rb_n = rb_low ? 1'b0 : 1'b1;
  fws_host i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n),
    .flash_addr(fa), .flash_dq_in(fi), .flash_dq_out(fo), .flash_dq_oe(dq_oe),
    .ready_busy_out_n(rb_n));
  fws_flash_model i_flash (.ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .addr(fa), .din(fo),
    .dout(fi), .rb_low(rb_low), .erase(erase), .stuck(stuck), .susp(susp), .nbusy(nbusy));
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // Expected polling bit while the bank is busy
  function automatic logic poll_exp(input logic er, input logic [DW-1:0] v);
    return er ? 1'b0 : ~v[7];
  endfunction : poll_exp
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : print_verdict
  // One APB transfer; read data and error taken at the pready edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    if (n >= 100) begin
      miscompares++;
      print_verdict();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  // Start an operation and poll until idle; status left in st
  task automatic run(input logic [1:0] op);
    int n;
    apb(1'b1, OFF_CTRL, {29'h0, op, 1'b1});
    n = 0;
    do begin
      apb(1'b0, OFF_STATUS, 32'h0);
      n++;
    end while (rd[ST_BUSY] !== 1'b0 && n < 500);
    if (n >= 500) begin
      miscompares++;
      print_verdict();
    end
    st = rd;
  endtask : run
  task automatic cmd(input logic [3:0] nb);
    nbusy <= nb;
    run(OP_WRITE);
  endtask : cmd
  initial begin
    {presetn, psel, penable, pwrite, erase, stuck, susp} = '0;
    {paddr, pwdata, nbusy, miscompares, n_tests} = '0;
    seed = 32'h39990e30;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    // Reset values, then one unmapped word
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, 12'(i * 4), 32'h0);
      chk("reset value", rd, (12'(i * 4) == OFF_STATUS) ? 32'h8 : 32'h0);
      chk("slave error", {31'h0, err}, {31'h0, i == 5});
    end
    // Program and erase, each waited on by polling and by toggling
    for (int k = 0; k < 4; k++) begin
      seed = lfsr(seed);
      erase <= k[0];
      d = k[0] ? 16'hffff : seed[15:0];
      apb(1'b1, OFF_ADDR, {14'h0, seed[31:14]});
      apb(1'b1, OFF_WDATA, {16'h0, d});
      cmd(4'(3 + seed[1:0]));
      apb(1'b0, OFF_STATUS, 32'h0);
      chk("ready pin", {31'h0, rd[ST_RDY_PIN]}, 32'h0);
      run(OP_READ);
      chk("erase timer", {31'h0, st[ST_ETMR]}, {31'h0, k[0]});
      chk("timeout flag", {31'h0, st[ST_TMO]}, 32'h0);
      apb(1'b0, OFF_RDATA, 32'h0);
      chk("polling bit", {31'h0, rd[POLL_BIT]}, {31'h0, poll_exp(k[0], d)});
      apb(1'b1, OFF_ADDR, {14'h0, seed[31:14] ^ 18'h10000});
      run(OP_READ);
      apb(1'b0, OFF_RDATA, 32'h0);
      chk("other bank", rd, {16'h0, seed[29:14]});
      apb(1'b1, OFF_ADDR, {14'h0, seed[31:14]});
      run(k[1] ? OP_POLLT : OP_POLLD);
      chk("done", {29'h0, st[2:0]}, 32'h2);
      chk("sector bit", {31'h0, st[ST_SECT]}, {31'h0, k[0]});
      apb(1'b0, OFF_CTRL, 32'h0);
      chk("op readback", rd, {29'h0, k[1] ? OP_POLLT : OP_POLLD, 1'b0});
      apb(1'b0, OFF_RDATA, 32'h0);
      chk("final data", rd, {16'h0, d});
    end
    // Operation that never ends: both waits must report failure
    stuck <= 1'b1;
    for (int j = 0; j < 2; j++) begin
      cmd(4'h5);
      run(j[0] ? OP_POLLT : OP_POLLD);
      chk("fail", {31'h0, st[ST_FAIL]}, 32'h1);
      chk("timeout seen", {31'h0, st[ST_TMO]}, 32'h1);
    end
    stuck <= 1'b0;
    cmd(4'h0);
    // Erase suspended: activity bit stops, line released
    cmd(4'h6);
    susp <= 1'b1;
    run(OP_POLLT);
    chk("suspend", {28'h0, st[3:0]}, 32'ha);
    chk("suspend sector", {31'h0, st[ST_SECT]}, 32'h1);
    susp <= 1'b0;
    cmd(4'h0);
    print_verdict();
  end
endmodule : fws_host_tb
